// ==== fmbv_pkg.sv ====
// ============================================================
// Shared constants and types for the mimic and violation monitor
package fmbv_pkg;

    // ============================================================
    // Register map (byte addresses)
    localparam logic [7:0] FMBV_STATUS_OFF   = 8'h00;
    localparam logic [7:0] FMBV_CTRL_OFF     = 8'h04;
    localparam logic [7:0] FMBV_IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] FMBV_IRQ_MASK_OFF = 8'h0C;

    // ============================================================
    // Field positions in the status words and status register
    localparam int FMBV_MIMIC_POS = 6;
    localparam int FMBV_B128_POS  = 4;
    localparam int FMBV_B64_POS   = 3;
    localparam int FMBV_PRIM_POS  = 2;

    // Interrupt status and mask bits
    localparam int FMBV_IRQ_MIMIC = 0;
    localparam int FMBV_IRQ_PRIM  = 1;
    localparam int FMBV_IRQ_B128  = 2;
    localparam int FMBV_IRQ_B64   = 3;

    // ============================================================
    // Reset values
    localparam logic [3:0] FMBV_IRQ_MASK_RST = 4'h0;
    localparam logic       FMBV_MODE_RST     = 1'b0;

    // ============================================================
    // Counts and timing
    localparam logic [7:0]  FMBV_PRIM_LAST   = 8'hFF;   // 256th violation
    localparam logic [5:0]  FMBV_B64_LAST    = 6'h3F;   // 64th violation
    localparam logic [6:0]  FMBV_B128_LAST   = 7'h7F;   // 128th violation
    localparam int          FMBV_CLK_HZ      = 20000000;
    localparam int          FMBV_REFRESH_MS  = 96;
    localparam int          FMBV_REFRESH_CYC = FMBV_REFRESH_MS * (FMBV_CLK_HZ / 1000);
    localparam logic [6:0]  FMBV_FRAMES      = 7'h48;   // 72 frames per superframe
    localparam logic [4:0]  FMBV_PAT_FRAMES  = 5'h18;   // Pattern occupies frames 2..24
    localparam logic [11:0] FMBV_RESYNC_PAT  = 12'h1C7; // 000111000111, frame 2 first

    // ============================================================
    // Primary counter states
    typedef enum logic [1:0]
    {
        FMBV_ST_COUNT = 2'b01,
        FMBV_ST_HOLD  = 2'b10
    } fmbv_prim_st_t;

endpackage

// ==== fmbv_viol_cnt.sv ====
`timescale 1ns/100ps
// ============================================================
// Violation counter with rate limited primary toggle
module fmbv_viol_cnt
#(
    parameter int REFRESH_CYC = fmbv_pkg::FMBV_REFRESH_CYC
)
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Violation pulse
    input  wire logic viol,
    // Toggle outputs
    output logic      prim_toggle,
    output logic      toggle_128,
    output logic      toggle_64
);
    import fmbv_pkg::*;

    localparam logic [20:0] LIMIT = 21'(REFRESH_CYC - 1);

    typedef struct packed {
        fmbv_prim_st_t st;
        logic [7:0]    cnt;
        logic [20:0]   timer;
        logic [6:0]    free;
        logic          prim;
        logic          b128;
        logic          b64;
    } fmbv_cnt_state_t;

    fmbv_cnt_state_t s;
    fmbv_cnt_state_t next_s;
    logic            expired;

    assign expired     = (s.timer == LIMIT);
    assign prim_toggle = s.prim;
    assign toggle_128  = s.b128;
    assign toggle_64   = s.b64;

    // ============================================================
    // Next state
    always_comb
    begin
        next_s = s;
        if (!expired)
        begin
            next_s.timer = s.timer + 21'h0_0001;
        end
        // Free running count for the unlimited bits
        if (viol)
        begin
            next_s.free = s.free + 7'h01;
            if (s.free[5:0] == FMBV_B64_LAST)
            begin
                next_s.b64 = ~s.b64;
            end
            if (s.free == FMBV_B128_LAST)
            begin
                next_s.b128 = ~s.b128;
            end
        end
        // Primary count, held off by the refresh timer
        unique case (s.st)
            FMBV_ST_COUNT:
            begin
                if (viol)
                begin
                    if (s.cnt == FMBV_PRIM_LAST)
                    begin
                        next_s.cnt = 8'h00;
                        if (expired)
                        begin
                            next_s.prim  = ~s.prim;
                            next_s.timer = 21'h00_0000;
                        end
                        else
                        begin
                            next_s.st = FMBV_ST_HOLD;
                        end
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 8'h01;
                    end
                end
            end
            FMBV_ST_HOLD:
            begin
                // Violations here are dropped
                next_s.cnt = 8'h00;
                if (expired)
                begin
                    next_s.prim  = ~s.prim;
                    next_s.timer = 21'h00_0000;
                    next_s.st    = FMBV_ST_COUNT;
                end
            end
            default:
            begin
                next_s.st = FMBV_ST_COUNT;
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{st: FMBV_ST_COUNT, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ============================================================
    // Checks
    logic [20:0] since;

    // Cycles since the last primary toggle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            since <= 21'h00_0000;
        end
        else if (s.prim != next_s.prim)
        begin
            since <= 21'h00_0000;
        end
        else if (since != LIMIT)
        begin
            since <= since + 21'h0_0001;
        end
    end

    AST_PRIM_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
        (s.prim != next_s.prim) |-> (since == LIMIT))
        else $error("Primary toggle came too soon");

    sequence fmbv_last_viol_s;
        s.st == FMBV_ST_COUNT && viol && s.cnt == FMBV_PRIM_LAST;
    endsequence

    AST_PRIM_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        fmbv_last_viol_s ##0 expired |=> (s.prim != $past(s.prim)))
        else $error("Primary bit missed its toggle");

    AST_HOLD_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        fmbv_last_viol_s ##0 !expired |=> (s.st == FMBV_ST_HOLD && s.cnt == 8'h00)
        ##1 (s.cnt == 8'h00))
        else $error("Violation counted during hold");

    AST_B64: assert property (@(posedge pclk) disable iff (!presetn)
        viol && s.free[5:0] == FMBV_B64_LAST |=> $changed(s.b64))
        else $error("Bit 3 did not toggle on 64th violation");

    AST_B128: assert property (@(posedge pclk) disable iff (!presetn)
        viol && s.free != FMBV_B128_LAST |=> $stable(s.b128))
        else $error("Bit 4 toggled off its count");

    AST_FREE_IND: assert property (@(posedge pclk) disable iff (!presetn)
        viol && s.st == FMBV_ST_HOLD |=> (s.free == $past(s.free) + 7'h01))
        else $error("Free count stalled by refresh hold");

endmodule // fmbv_viol_cnt

// ==== fmbv_monitor.sv ====
`timescale 1ns/100ps
module fmbv_monitor
#(
    parameter int REFRESH_CYC = fmbv_pkg::FMBV_REFRESH_CYC
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Line decoder events
    input  wire logic        viol_pulse,
    input  wire logic        sync_search,
    input  wire logic        candidate_hit,
    input  wire logic        resync_start,
    // Concentrator framing
    input  wire logic        frame_start,
    input  wire logic        user_fs_bit,
    output logic             framing_bit,
    // Serial status words
    output logic [7:0]       status_word1,
    output logic [7:0]       status_word2,
    // Interrupt
    output logic             irq
);
    import fmbv_pkg::*;

    typedef struct packed {
        logic [1:0]  cand;
        logic        mimic;
        logic        mode;
        logic [3:0]  istat;
        logic [3:0]  imask;
        logic [6:0]  frame;
        logic        fbit;
        logic [31:0] rdata;
        logic        slverr;
        logic [7:0]  sw1;
        logic [7:0]  sw2;
    } fmbv_mon_state_t;

    fmbv_mon_state_t s;
    fmbv_mon_state_t next_s;
    logic            prim;
    logic            b128;
    logic            b64;
    logic [3:0]      events;
    logic [6:0]      nf;
    logic [3:0]      pidx;

    // ============================================================
    // Address decode helpers
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == FMBV_STATUS_OFF) || (a == FMBV_CTRL_OFF) ||
                    (a == FMBV_IRQ_STAT_OFF) || (a == FMBV_IRQ_MASK_OFF);
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input fmbv_mon_state_t st);
        read_word = 32'h0000_0000;
        unique case (1'b1)
            a == FMBV_STATUS_OFF:   read_word = {17'h0_0000, st.frame, st.sw1};
            a == FMBV_CTRL_OFF:     read_word = {31'h0000_0000, st.mode};
            a == FMBV_IRQ_STAT_OFF: read_word = {28'h000_0000, st.istat};
            a == FMBV_IRQ_MASK_OFF: read_word = {28'h000_0000, st.imask};
            default:                read_word = 32'h0000_0000;
        endcase
    endfunction

    // ============================================================
    // Violation counter
    fmbv_viol_cnt #(
        .REFRESH_CYC (REFRESH_CYC)
    ) u_cnt (
        .pclk        (pclk),
        .presetn     (presetn),
        .viol        (viol_pulse),
        .prim_toggle (prim),
        .toggle_128  (b128),
        .toggle_64   (b64)
    );

    // Events seen as changes against the published status, the mimic bit on its rise only
    assign events[FMBV_IRQ_MIMIC] = s.mimic & ~s.sw1[FMBV_MIMIC_POS];
    assign events[FMBV_IRQ_PRIM]  = prim ^ s.sw1[FMBV_PRIM_POS];
    assign events[FMBV_IRQ_B128]  = b128 ^ s.sw2[FMBV_B128_POS];
    assign events[FMBV_IRQ_B64]   = b64 ^ s.sw2[FMBV_B64_POS];

    // Next frame number and pattern index
    assign nf   = (s.frame == FMBV_FRAMES || s.frame == 7'h00) ? 7'h01 : s.frame + 7'h01;
    assign pidx = 4'((nf >> 1) - 7'h01);

    // ============================================================
    // Next state
    always_comb
    begin
        next_s = s;
        // Mimic search, a resync starts a fresh candidate count
        if (resync_start)
        begin
            next_s.mimic = 1'b0;
            next_s.cand  = (sync_search && candidate_hit) ? 2'b01 : 2'b00;
        end
        else if (sync_search && candidate_hit)
        begin
            if (s.cand != 2'b00)
            begin
                next_s.mimic = 1'b1;
                next_s.cand  = 2'b10;
            end
            else
            begin
                next_s.cand = 2'b01;
            end
        end
        // Concentrator framing bit for the next frame
        if (frame_start)
        begin
            next_s.frame = nf;
            if (!s.mode)
            begin
                next_s.fbit = 1'b0;
            end
            else if (nf[0])
            begin
                next_s.fbit = ~nf[1];
            end
            else if (nf <= {2'b00, FMBV_PAT_FRAMES})
            begin
                next_s.fbit = FMBV_RESYNC_PAT[4'hB - pidx];
            end
            else
            begin
                next_s.fbit = user_fs_bit;
            end
        end
        // Status words
        next_s.sw1                 = 8'h00;
        next_s.sw1[FMBV_MIMIC_POS] = s.mimic;
        next_s.sw1[FMBV_PRIM_POS]  = prim;
        next_s.sw2                 = 8'h00;
        next_s.sw2[FMBV_B128_POS]  = b128;
        next_s.sw2[FMBV_B64_POS]   = b64;
        // Read data and error captured in setup phase
        if (psel && !penable)
        begin
            next_s.rdata  = pwrite ? 32'h0000_0000 : read_word(paddr, s);
            next_s.slverr = ~is_mapped(paddr);
        end
        // Writes at the access edge, interrupt set wins over clear
        for (int i = 0; i < 4; i++)
        begin
            if (psel && penable && pwrite && paddr == FMBV_IRQ_STAT_OFF && pwdata[i])
            begin
                next_s.istat[i] = 1'b0;
            end
            if (events[i])
            begin
                next_s.istat[i] = 1'b1;
            end
        end
        if (psel && penable && pwrite)
        begin
            if (paddr == FMBV_CTRL_OFF)
            begin
                next_s.mode = pwdata[0];
            end
            if (paddr == FMBV_IRQ_MASK_OFF)
            begin
                next_s.imask = pwdata[3:0];
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '{mode: FMBV_MODE_RST, imask: FMBV_IRQ_MASK_RST, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    assign prdata       = s.rdata;
    assign pready       = 1'b1;
    assign pslverr      = s.slverr & psel & penable;
    assign framing_bit  = s.fbit;
    assign status_word1 = s.sw1;
    assign status_word2 = s.sw2;
    assign irq          = |(s.istat & s.imask);

    // ============================================================
    // Checks
    sequence fmbv_two_hits_s;
        sync_search && candidate_hit && !resync_start
        ##1 sync_search && candidate_hit && !resync_start;
    endsequence

    AST_MIMIC_SET: assert property (@(posedge pclk) disable iff (!presetn)
        fmbv_two_hits_s |=> s.mimic)
        else $error("Mimic not set on second candidate");

    AST_MIMIC_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        resync_start ##1 (!(sync_search && candidate_hit) && !resync_start) |=> !s.mimic)
        else $error("Mimic set without a second candidate");

    AST_MIMIC_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        resync_start |=> !s.mimic)
        else $error("Mimic not cleared by resync");

    AST_SW1_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (status_word1[FMBV_MIMIC_POS] == $past(s.mimic)
             && status_word1[FMBV_PRIM_POS] == $past(prim)))
        else $error("Status word one bits misplaced");

    AST_FT_ODD: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start && s.mode && nf[0] |=> (framing_bit == ~s.frame[1]))
        else $error("Terminal framing bit wrong");

    AST_USER_FS: assert property (@(posedge pclk) disable iff (!presetn)
        frame_start && s.mode && !nf[0] && nf > 7'h18 |=> (framing_bit == $past(user_fs_bit)))
        else $error("User signalling framing bit not passed");

    AST_IRQ_EVT: assert property (@(posedge pclk) disable iff (!presetn)
        (events & s.imask) != 4'h0 |=> irq)
        else $error("Unmasked event raised no interrupt");

endmodule // fmbv_monitor

// ==== fmbv_line_model.sv ====
`timescale 1ns/100ps
// ============================================================
// Received line decoder stand-in, drives event pulses
module fmbv_line_model
(
    // Clock
    input  wire logic pclk,
    // Decoder events
    output logic      viol_pulse,
    output logic      sync_search,
    output logic      candidate_hit,
    output logic      resync_start,
    // Concentrator framing
    output logic      frame_start,
    output logic      user_fs_bit
);
    // Line levels, set by the tasks below
    logic v_q;
    logic s_q;
    logic c_q;
    logic r_q;
    logic f_q;
    logic u_q;

    // Idle levels at time zero
    initial
    begin
        v_q = 1'b0;
        s_q = 1'b0;
        c_q = 1'b0;
        r_q = 1'b0;
        f_q = 1'b0;
        u_q = 1'b0;
    end

    // Pins follow the line levels
    assign viol_pulse    = v_q;
    assign sync_search   = s_q;
    assign candidate_hit = c_q;
    assign resync_start  = r_q;
    assign frame_start   = f_q;
    assign user_fs_bit   = u_q;

    // Burst of back to back violations
    task automatic viols(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            v_q <= 1'b1;
        end
        @(posedge pclk);
        v_q <= 1'b0;
    endtask

    // Search level
    task automatic search(input logic s);
        @(posedge pclk);
        s_q <= s;
    endtask

    // One cycle candidate or resync pulse
    task automatic ev(input logic c, input logic r);
        @(posedge pclk);
        c_q <= c;
        r_q <= r;
        @(posedge pclk);
        c_q <= 1'b0;
        r_q <= 1'b0;
    endtask

    // Two candidates on consecutive edges
    task automatic ev2();
        @(posedge pclk);
        c_q <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        c_q <= 1'b0;
    endtask

    // Frame start with the user bit, inverted once released
    task automatic frame(input logic u);
        @(posedge pclk);
        f_q <= 1'b1;
        u_q <= u;
        @(posedge pclk);
        f_q <= 1'b0;
        u_q <= ~u;
    endtask
endmodule // fmbv_line_model

// ==== fmbv_tb.sv ====
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the mimic and violation monitor
module tb;
    import fmbv_pkg::*;

    localparam int          RCYC = 400;
    localparam logic [31:0] zero = 32'h0000_0000;

    // Bus and design signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        viol_pulse;
    logic        sync_search;
    logic        candidate_hit;
    logic        resync_start;
    logic        frame_start;
    logic        user_fs_bit;
    logic        framing_bit;
    logic [7:0]  status_word1;
    logic [7:0]  status_word2;
    logic        irq;
    // Bench state
    logic [31:0] rd;
    logic        err;
    logic        pr;
    logic        u;
    int          failures;
    int          comparisons;
    int          nv;
    int          fn;
    int          cyc;

    // Device under test
    fmbv_monitor #(.REFRESH_CYC(RCYC)) uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .viol_pulse(viol_pulse),
        .sync_search(sync_search), .candidate_hit(candidate_hit),
        .resync_start(resync_start), .frame_start(frame_start),
        .user_fs_bit(user_fs_bit), .framing_bit(framing_bit),
        .status_word1(status_word1), .status_word2(status_word2), .irq(irq)
    );

    // Line side partner
    fmbv_line_model lm
    (
        .pclk(pclk), .viol_pulse(viol_pulse), .sync_search(sync_search),
        .candidate_hit(candidate_hit), .resync_start(resync_start),
        .frame_start(frame_start), .user_fs_bit(user_fs_bit)
    );

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Cycles since reset release, same origin as refresh timer
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            cyc <= 0;
        else
            cyc <= cyc + 1;

    // ============================================================
    // Helpers
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            chk("pready", 32'h0000_0001, pready);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, zero);
        chk(n, e, rd);
    endtask

    // Let n edges pass, then look in the settled half cycle
    task automatic gap(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Both status words from mimic, primary and violation totals
    task automatic words(input logic m);
        chk("sw1", {1'b0, m, 3'b000, pr, 2'b00}, status_word1);
        chk("sw2", {3'b000, nv[7], nv[6], 3'b000}, status_word2);
    endtask

    // Framing bit of frame f with user bit v
    function automatic logic fexp(input int f, input logic v);
        if (f % 2 == 1)
            return (f % 4 == 1);
        if (f <= 24)
            return FMBV_RESYNC_PAT[12 - f / 2];
        return v;
    endfunction

    // Watchdog
    initial
    begin
        #200000;
        failures++;
        final_report();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = zero;
        failures    = 0;
        comparisons = 0;
        nv          = 0;
        fn          = 0;
        pr          = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and access kinds
        @(negedge pclk);
        words(1'b0);
        chk("irq", zero, irq);
        rdchk("status", FMBV_STATUS_OFF, zero);
        rdchk("ctrl", FMBV_CTRL_OFF, zero);
        rdchk("mask", FMBV_IRQ_MASK_OFF, zero);
        rdchk("istat", FMBV_IRQ_STAT_OFF, zero);
        apb(1'b1, FMBV_STATUS_OFF, 32'h0000_00FF);
        rdchk("status ro", FMBV_STATUS_OFF, zero);
        rdchk("unmapped", 8'h10, zero);
        chk("slverr", 32'h0000_0001, err);
        $display("reset test done");
        // Violation counts and refresh hold
        lm.viols(63);
        nv = 63;
        gap(3);
        words(1'b0);
        lm.viols(1);
        nv = 64;
        gap(3);
        words(1'b0);
        lm.viols(192);
        nv = 256;
        gap(3);
        words(1'b0);
        lm.viols(60);
        nv = 316;
        while (cyc < RCYC - 10) @(posedge pclk);
        @(negedge pclk);
        words(1'b0);
        while (cyc < RCYC + 5) @(posedge pclk);
        @(negedge pclk);
        pr = 1'b1;
        words(1'b0);
        lm.viols(196);
        nv = 512;
        gap(RCYC + 50);
        words(1'b0);
        lm.viols(60);
        nv = 572;
        gap(3);
        pr = 1'b0;
        words(1'b0);
        rdchk("istat", FMBV_IRQ_STAT_OFF, 32'h0000_000E);
        apb(1'b1, FMBV_IRQ_STAT_OFF, 32'h0000_000F);
        rdchk("istat", FMBV_IRQ_STAT_OFF, zero);
        $display("violation test done");
        // Mimic set, interrupt, resync clear
        lm.search(1'b1);
        lm.ev(1'b1, 1'b0);
        gap(3);
        words(1'b0);
        lm.ev(1'b1, 1'b0);
        gap(3);
        words(1'b1);
        rdchk("status", FMBV_STATUS_OFF, 32'h0000_0040);
        rdchk("istat", FMBV_IRQ_STAT_OFF, 32'h0000_0001);
        chk("irq masked", zero, irq);
        apb(1'b1, FMBV_IRQ_MASK_OFF, 32'h0000_0001);
        gap(1);
        chk("irq", 32'h0000_0001, irq);
        apb(1'b1, FMBV_IRQ_STAT_OFF, 32'h0000_0001);
        gap(1);
        chk("irq clr", zero, irq);
        lm.ev(1'b0, 1'b1);
        gap(3);
        words(1'b0);
        lm.ev2();
        gap(3);
        words(1'b1);
        lm.ev(1'b0, 1'b1);
        gap(3);
        words(1'b0);
        lm.search(1'b0);
        lm.ev(1'b1, 1'b0);
        lm.ev(1'b1, 1'b0);
        gap(3);
        words(1'b0);
        $display("mimic test done");
        // Concentrator framing over a full superframe and wrap
        lm.frame(1'b1);
        fn = 1;
        @(negedge pclk);
        chk("fbit off", zero, framing_bit);
        apb(1'b1, FMBV_CTRL_OFF, 32'h0000_0001);
        for (int i = 0; i < 73; i++)
        begin
            fn = fn % 72 + 1;
            u = fn[2] ^ fn[1];
            lm.frame(u);
            @(negedge pclk);
            chk("fbit", fexp(fn, u), framing_bit);
        end
        rdchk("frame", FMBV_STATUS_OFF, fn << 8);
        $display("framing test done");
        final_report();
    end
endmodule // tb
